// ===== hdl/bcbu_map.svh
// register offsets, field positions, reset values and response codes of the bit/branch unit
// What this block does
// - bit xor: carry becomes carry xor the selected operand bit
// - inverted bit xor: carry becomes carry xor the inverted selected bit
// - bit load: carry takes the selected operand bit
// - inverted bit load: carry takes the inverted selected operand bit
// - bit store: the selected operand bit takes the carry
// - inverted bit store: the selected operand bit takes the inverted carry
// - inverted forms take their bit number only from the 3-bit immediate
// - all bit-with-carry operations act on byte operands only
// - conditional branch taken when its condition holds, else sequential
// - unsigned conditions: higher, lower-or-same, higher-or-same, lower from carry and zero
// - return resumes at the address saved by the latest call that found room on the stack
// - plain forms take bit number from immediate or low three register bits
// - bit stores on memory read the byte, modify one bit, write it back
`ifndef BCBU_MAP_SVH
`define BCBU_MAP_SVH
`define BCBU_OFS_CMD     8'h00
`define BCBU_OFS_GPR     8'h04
`define BCBU_OFS_BITSEL  8'h08
`define BCBU_OFS_FLAGS   8'h0C
`define BCBU_OFS_PC      8'h10
`define BCBU_OFS_TARGET  8'h14
`define BCBU_OFS_MADDR   8'h18
`define BCBU_OFS_MDATA   8'h1C
`define BCBU_OFS_STATUS  8'h20
`define BCBU_OFS_RETTOP  8'h24
`define BCBU_CMD_OP_LSB   0
`define BCBU_CMD_IMM_LSB  8
`define BCBU_CMD_FROMREG  11
`define BCBU_CMD_INMEM    12
`define BCBU_CMD_COND_LSB 16
`define BCBU_FLAG_C 0
`define BCBU_FLAG_Z 1
`define BCBU_FLAG_N 2
`define BCBU_FLAG_V 3
`define BCBU_PC_RESET    32'h0000_0000
`define BCBU_FLAGS_RESET 4'h0
`define BCBU_INSN_BYTES  32'h0000_0002
`define BCBU_RESP_OKAY   2'h0
`define BCBU_RESP_SLVERR 2'h2
`endif

// ===== hdl/bcbu_pkg.sv
// types shared by the bit/branch unit
package bcbu_pkg;
    typedef enum logic [3:0] {
        BCBU_OP_NONE    = 4'h0,
        BCBU_OP_XOR     = 4'h1,
        BCBU_OP_IBXOR   = 4'h2,
        BCBU_OP_BLOAD   = 4'h3,
        BCBU_OP_IBLOAD  = 4'h4,
        BCBU_OP_CSTORE  = 4'h5,
        BCBU_OP_ICSTORE = 4'h6,
        BCBU_OP_BCOND   = 4'h8,
        BCBU_OP_JUMP    = 4'h9,
        BCBU_OP_RCALL   = 4'hA,
        BCBU_OP_ACALL   = 4'hB,
        BCBU_OP_RETURN  = 4'hC
    } bcbu_op_type;
    typedef enum logic [3:0] {
        BCBU_CC_ALWAYS = 4'h0, BCBU_CC_NEVER = 4'h1,
        BCBU_CC_HI     = 4'h2, BCBU_CC_LS    = 4'h3,
        BCBU_CC_HS     = 4'h4, BCBU_CC_LO    = 4'h5,
        BCBU_CC_NE     = 4'h6, BCBU_CC_EQ    = 4'h7,
        BCBU_CC_VC     = 4'h8, BCBU_CC_VS    = 4'h9,
        BCBU_CC_PL     = 4'hA, BCBU_CC_MI    = 4'hB,
        BCBU_CC_GE     = 4'hC, BCBU_CC_LT    = 4'hD,
        BCBU_CC_GT     = 4'hE, BCBU_CC_LE    = 4'hF
    } bcbu_cond_type;
    typedef struct packed {
        logic v;
        logic n;
        logic z;
        logic c;
    } bcbu_flags_type;
    typedef enum logic [1:0] {
        BCBU_ST_IDLE = 2'b00,
        BCBU_ST_READ = 2'b01,
        BCBU_ST_EXEC = 2'b10
    } bcbu_state_type;
endpackage

// ===== hdl/bcbu_top.sv
// bit-with-carry and branch condition unit behind an AXI4-Lite register slave
//
// The AXI4-Lite slave port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`include "bcbu_map.svh"
module bcbu_top
    import bcbu_pkg::*;
#(
    parameter int MEM_DEPTH   = 16,
    parameter int STACK_DEPTH = 8
) (
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);
    localparam int MAW = $clog2(MEM_DEPTH);
    localparam int SPW = $clog2(STACK_DEPTH + 1);
    localparam int SIW = $clog2(STACK_DEPTH);

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic cond_true(input bcbu_cond_type cc, input bcbu_flags_type f);
        logic r;
        unique case (cc)
            BCBU_CC_ALWAYS: r = 1'b1;
            BCBU_CC_NEVER:  r = 1'b0;
            BCBU_CC_HI:     r = (f.c | f.z) == 1'b0;
            BCBU_CC_LS:     r = (f.c | f.z) == 1'b1;
            BCBU_CC_HS:     r = !f.c;
            BCBU_CC_LO:     r = f.c;
            BCBU_CC_NE:     r = !f.z;
            BCBU_CC_EQ:     r = f.z;
            BCBU_CC_VC:     r = !f.v;
            BCBU_CC_VS:     r = f.v;
            BCBU_CC_PL:     r = !f.n;
            BCBU_CC_MI:     r = f.n;
            BCBU_CC_GE:     r = (f.n ^ f.v) == 1'b0;
            BCBU_CC_LT:     r = (f.n ^ f.v) == 1'b1;
            BCBU_CC_GT:     r = (f.z | (f.n ^ f.v)) == 1'b0;
            BCBU_CC_LE:     r = (f.z | (f.n ^ f.v)) == 1'b1;
        endcase
        return r;
    endfunction

    logic [31:0]          cmd_r;
    logic [7:0]           gpr_r;
    logic [2:0]           bitsel_r;
    bcbu_flags_type       flags_r;
    logic [31:0]          pc_r;
    logic [31:0]          target_r;
    logic [MAW-1:0]       maddr_r;
    logic [7:0]           mem_r [MEM_DEPTH];
    logic [31:0]          ret_r [STACK_DEPTH];
    logic [SPW-1:0]       sp_r;
    logic                 taken_r;
    logic                 stk_err_r;
    logic [7:0]           opnd_r;
    bcbu_state_type       state_r;
    bcbu_state_type       state_nxt;
    logic                 bvalid_r;
    logic [1:0]           bresp_r;
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    logic [1:0]           rresp_r;

    logic                 wr_fire;
    logic                 rd_fire;
    logic                 launch;
    bcbu_op_type          op;
    logic                 inverted;
    logic [2:0]           bit_idx;
    logic                 sel_bit;
    logic [7:0]           stored_byte;
    logic                 is_bitop;
    logic                 in_mem;
    logic [31:0]          seq_pc;
    logic [SIW-1:0]       top_idx;

    // one write at a time: both channels are taken together once the last answer is gone
    assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign s_axi_awready = wr_fire;
    assign s_axi_wready  = wr_fire;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign rd_fire       = s_axi_arvalid && !rvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    // a command written while busy is dropped; software polls the busy bit first
    assign launch   = wr_fire && s_axi_awaddr == `BCBU_OFS_CMD && state_r == BCBU_ST_IDLE;
    assign op       = bcbu_op_type'(cmd_r[`BCBU_CMD_OP_LSB +: 4]);
    assign inverted = op == BCBU_OP_IBXOR || op == BCBU_OP_IBLOAD || op == BCBU_OP_ICSTORE;
    assign is_bitop = op inside {BCBU_OP_XOR, BCBU_OP_IBXOR, BCBU_OP_BLOAD,
                                 BCBU_OP_IBLOAD, BCBU_OP_CSTORE, BCBU_OP_ICSTORE};
    assign in_mem   = cmd_r[`BCBU_CMD_INMEM];
    assign seq_pc   = pc_r + `BCBU_INSN_BYTES;
    // stack top; only meaningful while the stack is not empty
    assign top_idx  = SIW'(sp_r - SPW'(1));

    always_comb begin
        if (!inverted && cmd_r[`BCBU_CMD_FROMREG]) begin
            bit_idx = bitsel_r;
        end else begin
            bit_idx = cmd_r[`BCBU_CMD_IMM_LSB +: 3];
        end
        sel_bit     = opnd_r[bit_idx];
        stored_byte = opnd_r;
        stored_byte[bit_idx] = (op == BCBU_OP_ICSTORE) ? !flags_r.c : flags_r.c;
    end

    // every command spends one cycle in read before the execute cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            BCBU_ST_IDLE: begin
                if (launch) begin
                    state_nxt = BCBU_ST_READ;
                end
            end
            BCBU_ST_READ: state_nxt = BCBU_ST_EXEC;
            BCBU_ST_EXEC: state_nxt = BCBU_ST_IDLE;
            default:      state_nxt = BCBU_ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r <= BCBU_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cmd_r <= 32'h0000_0000;
        end else if (launch) begin
            cmd_r <= merge(cmd_r, s_axi_wdata, s_axi_wstrb);
        end
    end

    // operand latch: the whole byte is read once, from register or memory
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            opnd_r <= 8'h00;
        end else if (state_r == BCBU_ST_READ) begin
            opnd_r <= in_mem ? mem_r[maddr_r] : gpr_r;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gpr_r <= 8'h00;
        end else if (state_r == BCBU_ST_EXEC && !in_mem &&
                     (op == BCBU_OP_CSTORE || op == BCBU_OP_ICSTORE)) begin
            gpr_r <= stored_byte;
        end else if (wr_fire && s_axi_awaddr == `BCBU_OFS_GPR && s_axi_wstrb[0]) begin
            gpr_r <= s_axi_wdata[7:0];
        end
    end

    // memory is not reset; contents are whatever software or a memory bit store last wrote
    always_ff @(posedge ref_clk) begin
        if (state_r == BCBU_ST_EXEC && in_mem &&
            (op == BCBU_OP_CSTORE || op == BCBU_OP_ICSTORE)) begin
            mem_r[maddr_r] <= stored_byte;
        end else if (wr_fire && s_axi_awaddr == `BCBU_OFS_MDATA && s_axi_wstrb[0]) begin
            mem_r[maddr_r] <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bitsel_r <= 3'h0;
            target_r <= 32'h0000_0000;
            maddr_r  <= '0;
        end else if (wr_fire) begin
            if (s_axi_awaddr == `BCBU_OFS_BITSEL && s_axi_wstrb[0]) begin
                bitsel_r <= s_axi_wdata[2:0];
            end
            if (s_axi_awaddr == `BCBU_OFS_TARGET) begin
                target_r <= merge(target_r, s_axi_wdata, s_axi_wstrb);
            end
            if (s_axi_awaddr == `BCBU_OFS_MADDR && s_axi_wstrb[0]) begin
                maddr_r <= s_axi_wdata[MAW-1:0];
            end
        end
    end

    // the carry update of an executing command wins over a software flag write
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            flags_r <= `BCBU_FLAGS_RESET;
        end else if (state_r == BCBU_ST_EXEC && is_bitop &&
                     !(op == BCBU_OP_CSTORE || op == BCBU_OP_ICSTORE)) begin
            unique case (op)
                BCBU_OP_XOR:    flags_r.c <= flags_r.c ^ sel_bit;
                BCBU_OP_IBXOR:  flags_r.c <= flags_r.c ^ !sel_bit;
                BCBU_OP_BLOAD:  flags_r.c <= sel_bit;
                BCBU_OP_IBLOAD: flags_r.c <= !sel_bit;
                default:        flags_r.c <= flags_r.c;
            endcase
        end else if (wr_fire && s_axi_awaddr == `BCBU_OFS_FLAGS && s_axi_wstrb[0]) begin
            flags_r <= bcbu_flags_type'(s_axi_wdata[3:0]);
        end
    end

    // program counter and return stack; a full stack drops the push, an empty one
    // makes the return fall through, and both raise the sticky stack error
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pc_r      <= `BCBU_PC_RESET;
            sp_r      <= '0;
            taken_r   <= 1'b0;
            stk_err_r <= 1'b0;
        end else if (state_r == BCBU_ST_EXEC) begin
            taken_r <= 1'b0;
            pc_r    <= seq_pc;
            unique case (op)
                BCBU_OP_BCOND: begin
                    if (cond_true(bcbu_cond_type'(cmd_r[`BCBU_CMD_COND_LSB +: 4]), flags_r)) begin
                        pc_r    <= target_r;
                        taken_r <= 1'b1;
                    end
                end
                BCBU_OP_JUMP: begin
                    pc_r    <= target_r;
                    taken_r <= 1'b1;
                end
                BCBU_OP_RCALL, BCBU_OP_ACALL: begin
                    if (sp_r < SPW'(STACK_DEPTH)) begin
                        ret_r[sp_r[SIW-1:0]] <= seq_pc;
                        sp_r <= sp_r + SPW'(1);
                    end else begin
                        stk_err_r <= 1'b1;
                    end
                    pc_r    <= target_r;
                    taken_r <= 1'b1;
                end
                BCBU_OP_RETURN: begin
                    if (sp_r != '0) begin
                        pc_r    <= ret_r[top_idx];
                        sp_r    <= sp_r - SPW'(1);
                        taken_r <= 1'b1;
                    end else begin
                        stk_err_r <= 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end else if (wr_fire && s_axi_awaddr == `BCBU_OFS_PC) begin
            pc_r <= merge(pc_r, s_axi_wdata, s_axi_wstrb);
        end else if (wr_fire && s_axi_awaddr == `BCBU_OFS_STATUS && s_axi_wdata[2]) begin
            stk_err_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r  <= `BCBU_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_r <= 1'b1;
            bresp_r  <= (s_axi_awaddr > `BCBU_OFS_STATUS || s_axi_awaddr[1:0] != 2'h0)
                        ? `BCBU_RESP_SLVERR : `BCBU_RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rdata_r  <= 32'h0000_0000;
            rresp_r  <= `BCBU_RESP_OKAY;
        end else if (rd_fire) begin
            rvalid_r <= 1'b1;
            rresp_r  <= `BCBU_RESP_OKAY;
            rdata_r  <= 32'h0000_0000;
            unique case (s_axi_araddr)
                `BCBU_OFS_CMD:    rdata_r <= cmd_r;
                `BCBU_OFS_GPR:    rdata_r <= {24'h00_0000, gpr_r};
                `BCBU_OFS_BITSEL: rdata_r <= {29'h0000_0000, bitsel_r};
                `BCBU_OFS_FLAGS:  rdata_r <= {28'h000_0000, flags_r};
                `BCBU_OFS_PC:     rdata_r <= pc_r;
                `BCBU_OFS_TARGET: rdata_r <= target_r;
                `BCBU_OFS_MADDR:  rdata_r <= 32'(maddr_r);
                `BCBU_OFS_MDATA:  rdata_r <= {24'h00_0000, mem_r[maddr_r]};
                `BCBU_OFS_STATUS: rdata_r <= {16'h0000, 8'(sp_r), 5'h00, stk_err_r,
                                              taken_r, state_r != BCBU_ST_IDLE};
                `BCBU_OFS_RETTOP: rdata_r <= (sp_r != '0) ? ret_r[top_idx] : 32'h0000_0000;
                default:          rresp_r <= `BCBU_RESP_SLVERR;
            endcase
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule

// ===== sim/bcbu_top_sva.sv
// assertions on the register bus of the bit/branch unit
`timescale 1ns/1ns
`include "bcbu_map.svh"
module bcbu_top_sva (
    input wire logic        ref_clk,
    input wire logic        reset,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_wr_take; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid; endsequence
    sequence s_rd_take; s_axi_arvalid && !s_axi_rvalid; endsequence
    // status is the last writable word; the return top is read only
    sequence s_wr_bad;
        s_wr_take ##0 (s_axi_awaddr > `BCBU_OFS_STATUS || s_axi_awaddr[1:0] != 2'b00);
    endsequence
    sequence s_rd_bad;
        s_rd_take ##0 (s_axi_araddr > `BCBU_OFS_RETTOP || s_axi_araddr[1:0] != 2'b00);
    endsequence
    property p_wr_ready;
        s_axi_wready == s_axi_awready
            && s_axi_awready == (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid);
    endproperty
    property p_rd_ready; s_axi_arready == !s_axi_rvalid; endproperty
    property p_wr_resp; s_wr_take |=> s_axi_bvalid; endproperty
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_b_done; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    property p_wr_err; s_wr_bad |=> s_axi_bresp == `BCBU_RESP_SLVERR; endproperty
    property p_rd_resp; s_rd_take |=> s_axi_rvalid && !s_axi_arready; endproperty
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
            && $stable(s_axi_rresp);
    endproperty
    property p_rd_err;
        s_rd_bad |=> s_axi_rresp == `BCBU_RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_wr_ready: assert property (p_wr_ready) else $error("write ready wrong");
    a_rd_ready: assert property (p_rd_ready) else $error("read ready wrong");
    a_wr_resp: assert property (p_wr_resp) else $error("no write response");
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    a_b_done: assert property (p_b_done) else $error("write response stuck");
    a_wr_err: assert property (p_wr_err) else $error("bad write not refused");
    a_rd_resp: assert property (p_rd_resp) else $error("no read data");
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    a_rd_err: assert property (p_rd_err) else $error("bad read not refused");
endmodule

// ===== sim/bcbu_axi_master.sv
// register bus master standing in for software, able to stall its response side
`timescale 1ns/1ns
module bcbu_axi_master (
    input  wire logic        ref_clk,
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    logic slow = 1'b0;
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    // released lines show the inverse so a late sample cannot match by luck
    task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge ref_clk);
        {awaddr, wdata, wstrb} <= {a, v, 4'hF};
        {awvalid, wvalid, bready} <= {2'b11, !slow};
        forever begin
            @(posedge ref_clk);
            if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~a};
            if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~v};
            if (bvalid && bready) break;
            if (bvalid) bready <= 1'b1;
        end
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge ref_clk);
        {araddr, arvalid, rready} <= {a, 1'b1, !slow};
        forever begin
            @(posedge ref_clk);
            if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~a};
            if (rvalid && rready) break;
            if (rvalid) rready <= 1'b1;
        end
        {v, r} = {rdata, rresp};
        rready <= 1'b0;
    endtask
endmodule

// ===== sim/bit_carry_and_branch_condition_unit_tb_top.sv
// self-checking bench for the bit/branch unit
`timescale 1ns/1ns
`include "bcbu_map.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %0t got %h expected %h", $time, (g), (e)); end end
module bit_carry_and_branch_condition_unit_tb_top;
    logic        ref_clk, reset;
    logic [7:0]  awaddr, araddr, rg, eg;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, rf, ef;
    logic [1:0]  bresp, rresp, resp;
    logic [2:0]  rs;
    logic [19:0] rc;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          n_mismatch = 0, comparisons = 0, cyc = 0;
    // row: byte, bit select, flags {v,n,z,c}, command, expected flags, expected byte
    logic [46:0] rows [8] = '{
        {8'h80, 3'h0, 4'hF, 20'h00701, 4'hE, 8'h80}, {8'h08, 3'h3, 4'h0, 20'h00801, 4'h1, 8'h08},
        {8'h04, 3'h5, 4'h0, 20'h00A02, 4'h0, 8'h04}, {8'h01, 3'h0, 4'h6, 20'h00003, 4'h7, 8'h01},
        {8'h40, 3'h0, 4'h9, 20'h00604, 4'h8, 8'h40}, {8'h01, 3'h0, 4'h0, 20'h00C04, 4'h1, 8'h01},
        {8'h00, 3'h0, 4'h1, 20'h00405, 4'h1, 8'h10}, {8'hFF, 3'h0, 4'h9, 20'h00106, 4'h9, 8'hFD}};
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        u_mst.wr(a, v, resp);
    endtask
    task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
        u_mst.rd(a, d, resp);
        `CHK(d, e)
    endtask
    // busy lasts two cycles, so a few status polls are ample
    task automatic run(input logic [19:0] cmd);
        wr(`BCBU_OFS_CMD, {12'h0, cmd});
        d = 32'h1;
        for (int i = 0; i < 8 && d[0] !== 1'b0; i++) u_mst.rd(`BCBU_OFS_STATUS, d, resp);
        `CHK(d[0], 1'b0)
    endtask
    task automatic setup(input logic [7:0] gv, input logic [2:0] sv, input logic [3:0] fv);
        wr(`BCBU_OFS_GPR, {24'h0, gv});
        wr(`BCBU_OFS_BITSEL, {29'h0, sv});
        wr(`BCBU_OFS_FLAGS, {28'h0, fv});
        wr(`BCBU_OFS_PC, 32'h100);
        wr(`BCBU_OFS_TARGET, 32'h200);
    endtask
    function automatic logic taken(input logic [3:0] cc, input logic [3:0] fl);
        logic v, n, z, cy;
        logic [15:0] t;
        {v, n, z, cy} = fl;
        t = {z | (n ^ v), !(z | (n ^ v)), n ^ v, !(n ^ v), n, !n, v, !v, z, !z, cy, !cy,
             cy | z, !(cy | z), 1'b0, 1'b1};
        return t[cc];
    endfunction
    task automatic wrap_up;
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_mismatch++;
            wrap_up();
        end
    end
    initial begin
        reset = 1'b1;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        chk_rd(`BCBU_OFS_PC, 32'h0);
        chk_rd(`BCBU_OFS_FLAGS, 32'h0);
        foreach (rows[i]) begin
            {rg, rs, rf, rc, ef, eg} = rows[i];
            setup(rg, rs, rf);
            run(rc);
            chk_rd(`BCBU_OFS_FLAGS, {28'h0, ef});
            chk_rd(`BCBU_OFS_GPR, {24'h0, eg});
        end
        for (int cc = 0; cc < 16; cc++) begin
            for (int fl = 0; fl < 16; fl++) begin
                setup(8'h00, 3'h0, fl[3:0]);
                run({cc[3:0], 16'h0008});
                chk_rd(`BCBU_OFS_PC, taken(cc[3:0], fl[3:0]) ? 32'h200 : 32'h102);
            end
        end
        // nested calls unwind in reverse order
        setup(8'h00, 3'h0, 4'h0);
        run(20'h0000B);
        chk_rd(`BCBU_OFS_PC, 32'h200);
        chk_rd(`BCBU_OFS_RETTOP, 32'h102);
        wr(`BCBU_OFS_TARGET, 32'h300);
        run(20'h0000A);
        run(20'h0000C);
        chk_rd(`BCBU_OFS_PC, 32'h202);
        run(20'h0000C);
        chk_rd(`BCBU_OFS_PC, 32'h102);
        wr(`BCBU_OFS_TARGET, 32'h400);
        run(20'h00009);
        chk_rd(`BCBU_OFS_PC, 32'h400);
        chk_rd(`BCBU_OFS_STATUS, 32'h2);
        // return on an empty stack falls through and raises the sticky stack error
        run(20'h0000C);
        chk_rd(`BCBU_OFS_PC, 32'h402);
        chk_rd(`BCBU_OFS_STATUS, 32'h4);
        wr(`BCBU_OFS_STATUS, 32'h4);
        for (int i = 0; i < 9; i++) run(20'h0000B);
        chk_rd(`BCBU_OFS_STATUS, 32'h806);
        u_mst.slow = 1'b1;
        wr(`BCBU_OFS_MADDR, 32'h3);
        wr(`BCBU_OFS_MDATA, 32'hA5);
        wr(`BCBU_OFS_FLAGS, 32'h1);
        run(20'h01605);
        chk_rd(`BCBU_OFS_MDATA, 32'hE5);
        run(20'h01506);
        chk_rd(`BCBU_OFS_MDATA, 32'hC5);
        wr(`BCBU_OFS_FLAGS, 32'h0);
        run(20'h01203);
        chk_rd(`BCBU_OFS_FLAGS, 32'h1);
        wr(`BCBU_OFS_GPR, 32'h12345678);
        chk_rd(`BCBU_OFS_GPR, 32'h78);
        u_mst.rd(8'h28, d, resp);
        `CHK(resp, `BCBU_RESP_SLVERR)
        wr(`BCBU_OFS_RETTOP, 32'h0);
        `CHK(resp, `BCBU_RESP_SLVERR)
        wrap_up();
    end
    bcbu_axi_master u_mst (.ref_clk(ref_clk), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
    bcbu_top #(.MEM_DEPTH(16), .STACK_DEPTH(8)) dut (.ref_clk(ref_clk), .reset(reset),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
endmodule
bind bcbu_top bcbu_top_sva u_sva (.ref_clk(ref_clk), .reset(reset),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
